// *** dv/frame_src.sv ***
// frame field source in place of the parser pipeline
// assumes the matcher clock; one frame per send call
`timescale 1ns/100ps
module frame_src (
   input  wire logic  clk,
   output logic       frm_valid,
   output logic [53:0] fld
);
   // fields go to their inverse once taken, so stale values cannot match
   initial begin
      frm_valid = 1'b0;
      fld = 54'h0;
   end
   task automatic send(input logic [53:0] v);
      @(posedge clk);
      frm_valid <= 1'b1;
      fld <= v;
      @(posedge clk);
      frm_valid <= 1'b0;
      fld <= ~v;
   endtask
endmodule

// *** dv/l4_match_asserts.sv ***
// checker on the matcher result outputs
// assumes bind onto every l4_match instance
`timescale 1ns/100ps
module l4_match_asserts (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic frm_valid,
   input wire logic res_valid,
   input wire logic res_hit,
   input wire logic res_drop,
   input wire logic res_forward,
   input wire logic res_learn
);
   // ****************
   // result checks
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_res_follows: assert property (frm_valid |=> res_valid) else $error("result late");
   a_res_cause: assert property (res_valid |-> $past(frm_valid)) else $error("stray result");
   a_hit_qual: assert property (res_hit |-> res_valid) else $error("hit unqualified");
   a_drop_hit: assert property (res_drop |-> res_hit) else $error("drop on miss");
   a_miss_fwd: assert property (res_valid && !res_hit |-> res_forward && res_learn) else $error("miss held");
   a_learn_fwd: assert property (res_learn == res_forward) else $error("learn differs");
   a_drop_xor: assert property (res_valid |-> res_drop ^ res_forward) else $error("drop and forward");
   a_idle_quiet: assert property (!res_valid |-> !(res_hit | res_drop | res_forward)) else $error("idle out");
   // main outcomes seen
   cover property (res_hit && res_drop);
   cover property (res_hit && res_forward);
   cover property (res_valid && !res_hit);
endmodule
bind l4_match l4_match_asserts chk_u (.clk(clk), .rst_b(rst_b), .frm_valid(frm_valid), .res_valid(res_valid),
   .res_hit(res_hit), .res_drop(res_drop), .res_forward(res_forward), .res_learn(res_learn));

// *** dv/tb_top.sv ***
// random and corner frames against a bench model of one entry
// assumes design, checker and frame source compiled first
`timescale 1ns/100ps
`include "l4_match_consts.vh"
module tb_top;
   logic        clk, rst_b, wr, rd, fv, rv, hit, drop, fwd, lrn;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, ctrl, dp, fl, tos, icm;
   logic [53:0] fld, rf;
   logic [7:0]  lst [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h81, 8'h85, 8'h87};
   int          err_total, checks_done;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   frame_src src_u (.clk(clk), .frm_valid(fv), .fld(fld));
   l4_match dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .frm_valid(fv), .frm_next_hdr(fld[45:38]), .frm_dport(fld[37:22]), .frm_tcp_flags(fld[21:16]),
      .frm_tclass(fld[15:8]), .frm_icmp_type(fld[7:0]), .frm_icmp_code(fld[53:46]),
      .res_valid(rv), .res_hit(hit), .res_drop(drop), .res_forward(fwd), .res_learn(lrn));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   task automatic cfg;
      wr_reg(`A_CTRL, ctrl);
      wr_reg(`A_DPORT, dp);
      wr_reg(`A_FLAGS, fl);
      wr_reg(`A_TOS, tos);
      wr_reg(`A_ICMP, icm);
   endtask
   // bench model of the entry; icmp code travels in the top field byte
   function automatic logic exp_hit(input logic [53:0] v);
      logic ok;
      logic [1:0] s;
      ok = ctrl[0];
      case (ctrl[5:4])
         2'h1: ok &= v[37:22] == dp[15:0];
         2'h2: ok &= v[37:22] >= dp[15:0] && v[37:22] <= dp[31:16];
         2'h3: ok = 1'b0;
         default: ;
      endcase
      for (int g = 0; g < 6; g++) begin
         s = fl[2*g +: 2];
         if (s == `FLG_SET || s == `FLG_UNSET) ok &= v[45:38] == `NH_TCP && v[16+g] == (s == `FLG_SET);
      end
      case (ctrl[9:8])
         2'h1: ok &= v[15:10] == tos[5:0];
         2'h2: ok &= v[15:13] == tos[10:8];
         2'h3: ok = 1'b0;
         default: ;
      endcase
      case (ctrl[13:12])
         2'h1: ok &= v[7:0] == lst[icm[2:0]];
         2'h2: ok &= v[7:0] == icm[7:0];
         2'h3: ok = 1'b0;
         default: ;
      endcase
      if (ctrl[16]) ok &= v[53:46] == icm[15:8];
      return ok;
   endfunction
   task automatic frame(input logic [53:0] v);
      logic e, d;
      e = exp_hit(v);
      d = e & ctrl[1];
      src_u.send(v);
      #1 chk("result", {27'h0, 1'b1, e, d, ~d, ~d}, {27'h0, rv, hit, drop, fwd, lrn});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      {err_total, checks_done, wr, rd, addr, wdata} = '0;
      {ctrl, dp, fl, tos, icm} = '0;
      rst_b = 1'b0;
      void'($urandom(42386));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(`A_CTRL, `CTRL_RST);
      frame({`NH_TCP, 38'h0});
      ctrl = 32'h21;
      dp = 32'h0100_00ff;
      cfg;
      for (int i = 0; i < 4; i++) frame({`NH_TCP, 16'h00fe + 16'(i), 22'h0});
      for (int i = 0; i < 12; i++) begin
         ctrl = 32'h1;
         fl = (i % 2 + 1) << (i / 2 * 2);
         cfg;
         frame({`NH_TCP, 16'h0, 6'(1 << i / 2), 16'h0});
         frame({`NH_TCP, 38'h0});
         frame({`NH_ICMP6, 16'h0, 6'h3f, 16'h0});
      end
      ctrl = 32'h1001;
      fl = 0;
      for (int i = 0; i < 8; i++) begin
         icm = i;
         cfg;
         frame({`NH_ICMP6, 30'h0, lst[i]});
      end
      ctrl = 32'h31;
      cfg;
      frame({`NH_TCP, 38'h0});
      ctrl = 32'h1;
      cfg;
      wr_reg(`A_HITS, 32'h0);
      frame({`NH_ICMP6, 38'h15});
      rd_chk(`A_HITS, 32'h1);
      rd_chk(`A_STATUS, 32'h1);
      rd_chk(4'hf, `ZERO32);
      for (int n = 0; n < 300; n++) begin
         rf = {8'($urandom), $urandom % 2 ? `NH_TCP : `NH_ICMP6, 6'($urandom), $urandom};
         ctrl = {15'h0, 1'($urandom), 2'h0, 2'($urandom % 3), 2'h0, 2'($urandom % 3), 2'h0,
                 2'($urandom % 3), 2'h0, 1'($urandom), 1'b1};
         dp = {rf[37:22] + 16'($urandom % 3), rf[37:22] - 16'($urandom % 3)};
         fl = $urandom;
         tos = {21'h0, rf[15:13], 2'h0, rf[15:10] ^ 6'($urandom % 2)};
         icm = {16'h0, rf[53:46] ^ 8'($urandom % 2), rf[7:0] ^ 8'($urandom % 2)};
         cfg;
         frame(rf);
      end
      tally_and_finish;
   end
endmodule

// *** hw/flag_sel.v ***
// one tcp flag selector: set, unset or don't care
// assumes a registered two-bit selector and a parsed flag bit
`timescale 1ns/100ps
`include "l4_match_consts.vh"
module flag_sel (
   input  wire [1:0] sel,
   input  wire       flag,
   input  wire       is_tcp,
   output reg        pass
);
   // selector decode; non-tcp frames fail any active selector
   always @* begin
      case (sel)
         `FLG_SET:   pass = is_tcp & flag;
         `FLG_UNSET: pass = is_tcp & ~flag;
         default:    pass = 1'b1;
      endcase
   end
endmodule

// *** hw/l4_match.v ***
// filter entry matcher for layer-4 and service fields of one frame
// assumes a parser on the same clock giving one-cycle field strobes
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "l4_match_consts.vh"
module l4_match (
   input  wire        clk,
   input  wire        rst_b,
   input  wire [3:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [31:0] rdata,
   input  wire        frm_valid,
   input  wire [7:0]  frm_next_hdr,
   input  wire [15:0] frm_dport,
   input  wire [5:0]  frm_tcp_flags,
   input  wire [7:0]  frm_tclass,
   input  wire [7:0]  frm_icmp_type,
   input  wire [7:0]  frm_icmp_code,
   output reg         res_valid,
   output reg         res_hit,
   output reg         res_drop,
   output reg         res_forward,
   output reg         res_learn
);

   // ***************************
   // configuration registers
   // ***************************
   reg        enable_q;
   reg        action_q;
   reg [1:0]  dport_mode_q;
   reg [15:0] dport_lo_q;
   reg [15:0] dport_hi_q;
   reg [11:0] flags_q;
   reg [1:0]  tos_mode_q;
   reg [5:0]  dscp_q;
   reg [2:0]  prec_q;
   reg [1:0]  icmp_mode_q;
   reg [7:0]  icmp_val_q;
   reg        code_mode_q;
   reg [7:0]  code_q;
   reg        last_hit_q;
   reg [15:0] hits_q;

   // list of icmp message kinds selectable in list mode
   wire [7:0] kind_tab [0:7];
   assign kind_tab[0] = 8'h01;
   assign kind_tab[1] = 8'h02;
   assign kind_tab[2] = 8'h03;
   assign kind_tab[3] = 8'h04;
   assign kind_tab[4] = 8'h80;
   assign kind_tab[5] = 8'h81;
   assign kind_tab[6] = 8'h85;
   assign kind_tab[7] = 8'h87;

   // software writes; control bits steer the matcher directly
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_q     <= 1'b0;
         action_q     <= `ACT_PERMIT;
         dport_mode_q <= `SEL_ANY;
         dport_lo_q   <= 16'h0000;
         dport_hi_q   <= 16'h0000;
         flags_q      <= `FLAGS_RST;
         tos_mode_q   <= `SEL_ANY;
         dscp_q       <= 6'h00;
         prec_q       <= 3'h0;
         icmp_mode_q  <= `SEL_ANY;
         icmp_val_q   <= 8'h00;
         code_mode_q  <= 1'b0;
         code_q       <= 8'h00;
      end else if (wr) begin
         case (addr)
            `A_CTRL: begin
               enable_q     <= wdata[0];
               action_q     <= wdata[1];
               dport_mode_q <= wdata[5:4];
               tos_mode_q   <= wdata[9:8];
               icmp_mode_q  <= wdata[13:12];
               code_mode_q  <= wdata[16];
            end
            `A_DPORT: begin
               dport_lo_q <= wdata[15:0];        // single value also lives here
               dport_hi_q <= wdata[31:16];
            end
            `A_FLAGS: flags_q <= wdata[11:0];
            `A_TOS: begin
               dscp_q <= wdata[5:0];
               prec_q <= wdata[10:8];
            end
            `A_ICMP: begin
               icmp_val_q <= wdata[7:0];
               code_q     <= wdata[15:8];
            end
            default: ;
         endcase
      end
   end

   // ***************************
   // criterion evaluation
   // ***************************
   reg dport_ok;
   reg tos_ok;
   reg icmp_ok;
   wire code_ok;
   wire is_tcp;
   wire [5:0] flag_ok;

   assign is_tcp = (frm_next_hdr == `NH_TCP);

   // destination port; an inverted range simply never matches
   always @* begin
      case (dport_mode_q)
         `SEL_ANY: dport_ok = 1'b1;
         `SEL_ONE: dport_ok = (frm_dport == dport_lo_q);
         `SEL_TWO: dport_ok = (frm_dport >= dport_lo_q) && (frm_dport <= dport_hi_q);
         default:  dport_ok = 1'b0;
      endcase
   end

   // flags: bit 5 urgent, 4 ack, 3 push, 2 reset, 1 syn, 0 fin
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_flag
         flag_sel u_sel (
            .sel    (flags_q[2*g+1:2*g]),
            .flag   (frm_tcp_flags[g]),
            .is_tcp (is_tcp),
            .pass   (flag_ok[g])
         );
      end
   endgenerate

   // service field: dscp is top six bits, precedence top three
   always @* begin
      case (tos_mode_q)
         `SEL_ANY: tos_ok = 1'b1;
         `SEL_ONE: tos_ok = (frm_tclass[7:2] == dscp_q);
         `SEL_TWO: tos_ok = (frm_tclass[7:5] == prec_q);
         default:  tos_ok = 1'b0;
      endcase
   end

   // icmp kind; list mode indexes the fixed table with low bits
   always @* begin
      case (icmp_mode_q)
         `SEL_ANY: icmp_ok = 1'b1;
         `SEL_ONE: icmp_ok = (frm_icmp_type == kind_tab[icmp_val_q[2:0]]);
         `SEL_TWO: icmp_ok = (frm_icmp_type == icmp_val_q);
         default:  icmp_ok = 1'b0;
      endcase
   end

   assign code_ok = ~code_mode_q | (frm_icmp_code == code_q);

   wire hit;
   assign hit = enable_q & dport_ok & (&flag_ok) & tos_ok & icmp_ok & code_ok;

   // ***************************
   // result and statistics
   // ***************************
   // one cycle latency from frame strobe to registered verdict
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         res_valid   <= 1'b0;
         res_hit     <= 1'b0;
         res_drop    <= 1'b0;
         res_forward <= 1'b0;
         res_learn   <= 1'b0;
         last_hit_q  <= 1'b0;
         hits_q      <= 16'h0000;
      end else begin
         res_valid   <= frm_valid;
         res_hit     <= frm_valid & hit;
         res_drop    <= frm_valid & hit & (action_q == `ACT_DENY);
         res_forward <= frm_valid & ~(hit & (action_q == `ACT_DENY));
         res_learn   <= frm_valid & ~(hit & (action_q == `ACT_DENY));
         if (frm_valid)
            last_hit_q <= hit;
         // counter saturates rather than wraps; a write clears it unless a hitting frame counts in the same cycle
         if (frm_valid & hit & (hits_q != 16'hffff))
            hits_q <= hits_q + 16'h0001;
         else if (wr && addr == `A_HITS)
            hits_q <= 16'h0000;
      end
   end

   // ***************************
   // register read-back
   // ***************************
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `ZERO32;
      end else if (rd) begin
         case (addr)
            `A_CTRL:   rdata <= {15'h0000, code_mode_q, 2'h0, icmp_mode_q, 2'h0, tos_mode_q,
                                 2'h0, dport_mode_q, 2'h0, action_q, enable_q};
            `A_DPORT:  rdata <= {dport_hi_q, dport_lo_q};
            `A_FLAGS:  rdata <= {20'h00000, flags_q};
            `A_TOS:    rdata <= {21'h000000, prec_q, 2'h0, dscp_q};
            `A_ICMP:   rdata <= {16'h0000, code_q, icmp_val_q};
            `A_STATUS: rdata <= {31'h00000000, last_hit_q};
            `A_HITS:   rdata <= {16'h0000, hits_q};
            default:   rdata <= `ZERO32;
         endcase
      end else begin
         rdata <= `ZERO32;
      end
   end

endmodule

// *** hw/l4_match_consts.vh ***
// constants for the ipv6 layer-4 filter entry matcher
// assumes inclusion by bare name from the design files
`ifndef L4_MATCH_CONSTS_VH
`define L4_MATCH_CONSTS_VH

// ***************************
// register offsets (indices)
// ***************************
`define A_CTRL      4'h0
`define A_DPORT     4'h1
`define A_FLAGS     4'h2
`define A_TOS       4'h3
`define A_ICMP      4'h4
`define A_STATUS    4'h5
`define A_HITS      4'h6

// ***************************
// field selectors, codes and reset values
// ***************************
`define SEL_ANY     2'h0
`define SEL_ONE     2'h1
`define SEL_TWO     2'h2
`define FLG_SET     2'h1
`define FLG_UNSET   2'h2
`define NH_TCP      8'h06
`define NH_ICMP6    8'h3a
`define ACT_PERMIT  1'h0
`define ACT_DENY    1'h1
`define ZERO32      32'h0000_0000
`define CTRL_RST    32'h0000_0000
`define FLAGS_RST   12'h000

`endif
